// >>> vref_ctrl_pkg.sv
// package: register map, field layout, reset values and state names for the reference control block
// assumes a 32-bit avalon-mm word bus with byte addressing
package vref_ctrl_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
	localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;
	localparam int BIT_REF_ENABLE = 7;
	localparam int BIT_READY = 6;
	localparam int BIT_TEMP_ENABLE = 5;
	localparam int BIT_TEMP_RANGE = 4;
	localparam int OPAMP_GAIN_LSB = 2;
	localparam int ADC_GAIN_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'hbf;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	localparam int IRQ_READY_RISE = 0;
	localparam int IRQ_READY_FALL = 1;
	typedef enum logic [1:0] {
		GAIN_OFF,
		GAIN_1X,
		GAIN_2X,
		GAIN_4X
	} gain_e;
	typedef enum {
		BUS_IDLE,
		BUS_DONE
	} bus_state_e;
endpackage : vref_ctrl_pkg

// >>> fixed_reference_control.sv
// fixed voltage reference control register bank with ready tracking and interrupt
// assumes the analog reference reports stabilisation asynchronously on STABLE_IN
// Notes on behaviour
// R1: one 8-bit control register: enable7, ready6, temp5, range4, opamp gain3-2, adc gain1-0.
// R2: ready flag is read-only, reads 1 when output usable, writes ignored.
// R3: ready reads 0 while disabled, or enabled but not yet stable.
// R4: temperature enable bit drives the temperature indicator enable.
// R5: range select 1 selects high range, 0 selects low range.
// R6: op amp gain 01,10,11 decode to 1x,2x,4x.
// R7: op amp gain 00 switches off the op amp buffer.
// R8: adc gain 01,10,11 decode to 1x,2x,4x.
// R9: adc gain 00 switches off the adc buffer.
// R10: enable bit turns the reference on, clear turns it off.
// R11: ready becomes 1 only after circuits report stabilised.
// R12: reset clears writable fields; ready follows live stabilisation condition.
`timescale 1ns/1ps
module fixed_reference_control
	import vref_ctrl_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic [vref_ctrl_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic STABLE_IN,
	output logic REF_ENABLE,
	output logic TEMP_ENABLE,
	output logic TEMP_HIGH_RANGE,
	output logic OPAMP_BUF_ON,
	output logic [2:0] OPAMP_GAIN_ONEHOT,
	output logic ADC_BUF_ON,
	output logic [2:0] ADC_GAIN_ONEHOT,
	output logic IRQ
);
	import vref_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// decoding

	// one-hot gain control: bit0 1x, bit1 2x, bit2 4x; zero when off
	function automatic logic [2:0] gain_onehot(input logic [1:0] sel);
		logic [2:0] r;
		r = 3'h0;
		unique case (gain_e'(sel))
			GAIN_OFF: r = 3'h0;
			GAIN_1X: r = 3'h1;
			GAIN_2X: r = 3'h2;
			GAIN_4X: r = 3'h4;
		endcase
		return r;
	endfunction : gain_onehot

	logic [7:0] ctrl_ff;
	logic [1:0] irq_status_ff;
	logic [1:0] irq_mask_ff;
	logic [2:0] stable_sync_ff;
	logic stable_ff;
	logic ready_ff;
	logic [31:0] rdata_ff;
	bus_state_e bus_ff;
	logic nxt_ready;
	logic access;
	logic wr_fire;
	logic ready_rise;
	logic ready_fall;

	////////////////////////////////////////////////////////////////////////
	// stabilisation input: three-stage sync, change accepted when stages 2 and 3 agree
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			stable_sync_ff <= 3'h0;
			stable_ff <= 1'b0;
		end else begin
			stable_sync_ff <= {stable_sync_ff[1:0], STABLE_IN};
			if (stable_sync_ff[1] == stable_sync_ff[2]) begin
				stable_ff <= stable_sync_ff[2];
			end
		end
	end

	// ready is live, never stored by software; gated by enable so a disable drops it at once
	assign nxt_ready = ctrl_ff[BIT_REF_ENABLE] & stable_ff; // R3 R11 R12

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= nxt_ready; // R2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, answer in the second cycle of the request
	assign access = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = access & (bus_ff == BUS_IDLE);
	// a write lands only at the edge where the master sees waitrequest low, never in the wait cycle
	assign wr_fire = AVS_WRITE & (bus_ff == BUS_DONE);
	assign AVS_READDATA = rdata_ff;

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			bus_ff <= BUS_IDLE;
		end else begin
			unique case (bus_ff)
				BUS_IDLE: bus_ff <= access ? BUS_DONE : BUS_IDLE;
				BUS_DONE: bus_ff <= BUS_IDLE;
			endcase
		end
	end

	// read data captured a cycle early so it stands with waitrequest low
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			rdata_ff <= 32'h0;
		end else if (AVS_READ && bus_ff == BUS_IDLE) begin
			unique case (AVS_ADDRESS)
				CTRL_OFFSET: rdata_ff <= {24'h0, ctrl_ff[7], nxt_ready, ctrl_ff[5:0]}; // R1 R2
				IRQ_STATUS_OFFSET: rdata_ff <= {30'h0, irq_status_ff};
				IRQ_MASK_OFFSET: rdata_ff <= {30'h0, irq_mask_ff};
				default: rdata_ff <= 32'h0; // unmapped reads zero
			endcase
		end
	end

	// control register; bit 6 is masked out of every write
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			ctrl_ff <= CTRL_RESET; // R12
		end else if (wr_fire && AVS_ADDRESS == CTRL_OFFSET && AVS_BYTEENABLE[0]) begin
			ctrl_ff <= AVS_WRITEDATA[7:0] & CTRL_WRITE_MASK; // R1 R2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: ready rise and fall events, write one to clear, set wins
	assign ready_rise = nxt_ready & ~ready_ff;
	assign ready_fall = ~nxt_ready & ready_ff;

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			irq_status_ff <= IRQ_RESET;
		end else begin
			irq_status_ff <= (irq_status_ff
				& ~((wr_fire && AVS_ADDRESS == IRQ_STATUS_OFFSET && AVS_BYTEENABLE[0])
					? AVS_WRITEDATA[1:0] : 2'h0))
				| {ready_fall, ready_rise};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			irq_mask_ff <= IRQ_RESET;
		end else if (wr_fire && AVS_ADDRESS == IRQ_MASK_OFFSET && AVS_BYTEENABLE[0]) begin
			irq_mask_ff <= AVS_WRITEDATA[1:0];
		end
	end

	assign IRQ = |(irq_status_ff & irq_mask_ff);

	////////////////////////////////////////////////////////////////////////
	// analog controls straight from register bits
	assign REF_ENABLE = ctrl_ff[BIT_REF_ENABLE]; // R10
	assign TEMP_ENABLE = ctrl_ff[BIT_TEMP_ENABLE]; // R4
	assign TEMP_HIGH_RANGE = ctrl_ff[BIT_TEMP_RANGE]; // R5
	assign OPAMP_GAIN_ONEHOT = gain_onehot(ctrl_ff[OPAMP_GAIN_LSB+:2]); // R6
	assign OPAMP_BUF_ON = |ctrl_ff[OPAMP_GAIN_LSB+:2]; // R7
	assign ADC_GAIN_ONEHOT = gain_onehot(ctrl_ff[ADC_GAIN_LSB+:2]); // R8
	assign ADC_BUF_ON = |ctrl_ff[ADC_GAIN_LSB+:2]; // R9

	////////////////////////////////////////////////////////////////////////
	// checks
	// sequences name the steps of a transfer so the properties read like the bus walk

	sequence s_enable_write;
		wr_fire && AVS_ADDRESS == CTRL_OFFSET && AVS_BYTEENABLE[0];
	endsequence

	sequence s_request_open;
		(AVS_READ || AVS_WRITE) && bus_ff == BUS_IDLE;
	endsequence

	sequence s_answer;
		!AVS_WAITREQUEST && bus_ff == BUS_DONE;
	endsequence

	sequence s_ctrl_read;
		AVS_READ && bus_ff == BUS_IDLE && AVS_ADDRESS == CTRL_OFFSET;
	endsequence

	sequence s_status_clear;
		wr_fire && AVS_ADDRESS == IRQ_STATUS_OFFSET && AVS_BYTEENABLE[0];
	endsequence

	sequence s_mask_write;
		wr_fire && AVS_ADDRESS == IRQ_MASK_OFFSET && AVS_BYTEENABLE[0];
	endsequence

	// a disable must pull ready down by the next edge
	a_ready_needs_enable: assert property (@(posedge CLOCK) disable iff (!RST_B) // R3
		!REF_ENABLE |-> ##1 !ready_ff) else $error("ready while disabled");

	// ready never runs ahead of the filtered stable level
	a_ready_needs_stable: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		ready_ff |-> $past(stable_ff)) else $error("ready without stable");

	// the flag position is never stored from a write
	a_ready_readonly: assert property (@(posedge CLOCK) disable iff (!RST_B) // R2
		s_enable_write |=> ctrl_ff[BIT_READY] == 1'b0) else $error("ready bit stored");

	// accepted control writes land masked
	a_ctrl_write: assert property (@(posedge CLOCK) disable iff (!RST_B) // R1
		s_enable_write |=> ctrl_ff == ($past(AVS_WRITEDATA[7:0]) & CTRL_WRITE_MASK)) else $error("ctrl write lost");

	// temperature controls follow their bits
	a_temp_follow: assert property (@(posedge CLOCK) disable iff (!RST_B) // R4 R5
		TEMP_ENABLE == ctrl_ff[5] && TEMP_HIGH_RANGE == ctrl_ff[4]) else $error("temp control wrong");

	// op amp 4x code
	a_opamp_gain: assert property (@(posedge CLOCK) disable iff (!RST_B) // R6
		(ctrl_ff[3:2] == 2'h3) |-> OPAMP_GAIN_ONEHOT == 3'h4 && OPAMP_BUF_ON) else $error("opamp 4x");

	// op amp buffer off on code zero
	a_opamp_off: assert property (@(posedge CLOCK) disable iff (!RST_B) // R7
		(ctrl_ff[3:2] == 2'h0) |-> !OPAMP_BUF_ON && OPAMP_GAIN_ONEHOT == 3'h0) else $error("opamp on");

	// adc 2x code
	a_adc_gain: assert property (@(posedge CLOCK) disable iff (!RST_B) // R8
		(ctrl_ff[1:0] == 2'h2) |-> ADC_GAIN_ONEHOT == 3'h2 && ADC_BUF_ON) else $error("adc 2x");

	// adc buffer off on code zero
	a_adc_off: assert property (@(posedge CLOCK) disable iff (!RST_B) // R9
		(ctrl_ff[1:0] == 2'h0) |-> !ADC_BUF_ON) else $error("adc on");

	// reset leaves the reference off and every field clear
	a_enable_reset: assert property (@(posedge CLOCK) // R10 R12
		!RST_B |=> ctrl_ff == 8'h00 && !REF_ENABLE) else $error("reset not cleared");

	////////////////////////////////////////////////////////////////////////
	// bus, interrupt, ready and gain decode checks

	// exactly one wait state, then the answer
	a_wait_once: assert property (@(posedge CLOCK) disable iff (!RST_B) // R1
		s_request_open |-> AVS_WAITREQUEST ##1 s_answer) else $error("wait state count");

	// the control register is not written while waitrequest is still high
	a_write_held_off: assert property (@(posedge CLOCK) disable iff (!RST_B) // R1
		AVS_WRITE && bus_ff == BUS_IDLE |=> ctrl_ff == $past(ctrl_ff)) else $error("early write");

	// control readback carries the live ready level
	a_read_ctrl: assert property (@(posedge CLOCK) disable iff (!RST_B) // R1 R2
		s_ctrl_read |=> AVS_READDATA == {24'h0, $past(ctrl_ff[7]), $past(nxt_ready), $past(ctrl_ff[5:0])})
		else $error("ctrl readback");

	// a ready rise is latched even against a clear
	a_rise_sets: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		ready_rise |=> irq_status_ff[IRQ_READY_RISE]) else $error("rise lost");

	// a ready fall is latched even against a clear
	a_fall_sets: assert property (@(posedge CLOCK) disable iff (!RST_B) // R3
		ready_fall |=> irq_status_ff[IRQ_READY_FALL]) else $error("fall lost");

	// write one clears when no event competes
	a_clear_status: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		s_status_clear ##0 (!ready_rise && !ready_fall) |=> (irq_status_ff & $past(AVS_WRITEDATA[1:0])) == 2'h0)
		else $error("status not cleared");

	// mask takes the written bits
	a_mask_write: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		s_mask_write |=> irq_mask_ff == $past(AVS_WRITEDATA[1:0])) else $error("mask write lost");

	// a clear mask keeps the line quiet
	a_irq_masked: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		(irq_mask_ff == 2'h0) |-> !IRQ) else $error("irq while masked");

	// ready only rises from enable with a stable report
	a_ready_late: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		$rose(ready_ff) |-> $past(stable_ff) && $past(REF_ENABLE)) else $error("ready rose early");

	// clearing enable drops ready one edge later
	a_ready_drop: assert property (@(posedge CLOCK) disable iff (!RST_B) // R3 R10
		$fell(REF_ENABLE) |=> !ready_ff) else $error("ready kept after disable");

	// the filtered level only moves when the last two stages agree
	a_stable_filter: assert property (@(posedge CLOCK) disable iff (!RST_B) // R11
		$changed(stable_ff) |-> $past(stable_sync_ff[1]) == $past(stable_sync_ff[2])) else $error("filter");

	// op amp 1x code
	a_opamp_1x: assert property (@(posedge CLOCK) disable iff (!RST_B) // R6
		(ctrl_ff[3:2] == 2'h1) |-> OPAMP_GAIN_ONEHOT == 3'h1 && OPAMP_BUF_ON) else $error("opamp 1x");

	// op amp 2x code
	a_opamp_2x: assert property (@(posedge CLOCK) disable iff (!RST_B) // R6
		(ctrl_ff[3:2] == 2'h2) |-> OPAMP_GAIN_ONEHOT == 3'h2 && OPAMP_BUF_ON) else $error("opamp 2x");

	// adc 1x code
	a_adc_1x: assert property (@(posedge CLOCK) disable iff (!RST_B) // R8
		(ctrl_ff[1:0] == 2'h1) |-> ADC_GAIN_ONEHOT == 3'h1 && ADC_BUF_ON) else $error("adc 1x");

	// adc 4x code
	a_adc_4x: assert property (@(posedge CLOCK) disable iff (!RST_B) // R8
		(ctrl_ff[1:0] == 2'h3) |-> ADC_GAIN_ONEHOT == 3'h4 && ADC_BUF_ON) else $error("adc 4x");

	// no gain line stays on with the adc buffer off
	a_adc_off_gain: assert property (@(posedge CLOCK) disable iff (!RST_B) // R9
		(ctrl_ff[1:0] == 2'h0) |-> ADC_GAIN_ONEHOT == 3'h0) else $error("adc gain while off");

endmodule : fixed_reference_control

// >>> fixed_reference_control_bench.sv
// testbench for the reference control register bank and its interrupt
// assumes the package and design are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module fixed_reference_control_bench;
	import vref_ctrl_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic stable = 1'b0;
	logic [31:0] rdata;
	logic waitreq, ref_en, temp_en, temp_hi, op_on, adc_on, irq;
	logic [2:0] op_oh, adc_oh, oh;
	logic [31:0] got;
	int err_count = 0;
	int samples_checked = 0;
	////////////////////////////////////////////////////////////////////////////////
	fixed_reference_control u_dut (.CLOCK(clock), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .STABLE_IN(stable), .REF_ENABLE(ref_en), .TEMP_ENABLE(temp_en),
		.TEMP_HIGH_RANGE(temp_hi), .OPAMP_BUF_ON(op_on), .OPAMP_GAIN_ONEHOT(op_oh), .ADC_BUF_ON(adc_on),
		.ADC_GAIN_ONEHOT(adc_oh), .IRQ(irq));
	// 125 mhz clock
	initial begin
		forever #4 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	// compare and count; an unknown never matches
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		addr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clock);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		got = rdata;
		chk({31'h0, waitreq}, 32'h0);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(got, exp);
	endtask : rdchk
	// all analog control and irq outputs packed; checked at the falling edge once updates have landed
	task automatic outs(input logic [11:0] exp);
		@(negedge clock);
		chk({20'h0, ref_en, temp_en, temp_hi, op_on, op_oh, adc_on, adc_oh, irq}, {20'h0, exp});
	endtask : outs
	task automatic stop_test;
		if (err_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clock);
		err_count++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		rdchk(CTRL_OFFSET, 32'h0);
		rdchk(IRQ_STATUS_OFFSET, 32'h0);
		rdchk(IRQ_MASK_OFFSET, 32'h0);
		outs(12'h000);
		// every gain code on both fields; bit 6 written as one must stay clear
		for (int g = 0; g < 4; g++) begin
			bus(1'b1, CTRL_OFFSET, {2'b11, g[1:0], g[1:0], g[1:0]});
			rdchk(CTRL_OFFSET, {24'h0, 2'b10, g[1:0], g[1:0], g[1:0]});
			oh = (g == 0) ? 3'b000 : 3'b001 << (g - 1);
			outs({1'b1, g[1], g[0], g != 0, oh, g != 0, oh, 1'b0});
		end
		// ready rises only after the analog side reports stable
		bus(1'b1, IRQ_MASK_OFFSET, 8'h03);
		stable <= 1'b1;
		repeat (12) @(posedge clock);
		rdchk(CTRL_OFFSET, 32'hff);
		rdchk(IRQ_STATUS_OFFSET, 32'h1);
		outs(12'hf99);
		bus(1'b1, IRQ_STATUS_OFFSET, 8'h01);
		outs(12'hf98);
		// disabling drops ready although stable is still high
		bus(1'b1, CTRL_OFFSET, 8'h3f);
		repeat (3) @(posedge clock);
		rdchk(CTRL_OFFSET, 32'h3f);
		rdchk(IRQ_STATUS_OFFSET, 32'h2);
		outs(12'h799);
		bus(1'b1, IRQ_MASK_OFFSET, 8'h00);
		outs(12'h798);
		// unmapped place and disabled byte lane are refused
		bus(1'b1, 4'hc, 8'hff);
		rdchk(4'hc, 32'h0);
		be <= 4'he;
		bus(1'b1, CTRL_OFFSET, 8'h80);
		be <= 4'hf;
		rdchk(CTRL_OFFSET, 32'h3f);
		// second reset in mid-run
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rdchk(CTRL_OFFSET, 32'h0);
		outs(12'h000);
		stop_test();
	end
endmodule : fixed_reference_control_bench
